// File: rtl/ctc_params.svh
`ifndef CTC_PARAMS_SVH
`define CTC_PARAMS_SVH

// Register offsets on the plain register port.
`define CTC_OFS_CONTROL 8'h88
`define CTC_OFS_MODE 8'h89
`define CTC_OFS_LO0 8'h8a
`define CTC_OFS_LO1 8'h8b
`define CTC_OFS_HI0 8'h8c
`define CTC_OFS_HI1 8'h8d
`define CTC_OFS_CTL2 8'hc8
`define CTC_OFS_RLD2_LO 8'hca
`define CTC_OFS_RLD2_HI 8'hcb
`define CTC_OFS_THIRD_TIMER_COUNT_SOURCE_LO 8'hcc
`define CTC_OFS_THIRD_TIMER_COUNT_SOURCE_HI 8'hcd

// Reset values.
`define CTC_RST_BYTE 8'h00
`define CTC_RST_WORD 16'h0000

// Timer control register fields.
`define CTC_CTL_OVF1 7
`define CTC_CTL_RUN1 6
`define CTC_CTL_OVF0 5
`define CTC_CTL_RUN0 4

// Mode register fields, one nibble per timer.
`define CTC_MODE_T1_LSB 4
`define CTC_MODE_T0_LSB 0

// Third timer control fields.
`define CTC_C2_OVF 7
`define CTC_C2_EXT 6
`define CTC_C2_RXSEL 5
`define CTC_C2_TXSEL 4
`define CTC_C2_TRIGEN 3
`define CTC_C2_RUN 2
`define CTC_C2_SRC 1
`define CTC_C2_CAPSEL 0

// Synchronised pin positions.
`define CTC_PIN_CNT0 0
`define CTC_PIN_CNT1 1
`define CTC_PIN_GATE0 2
`define CTC_PIN_GATE1 3
`define CTC_PIN_THIRD_TIMER_COUNT_SOURCE 4
`define CTC_PIN_TRIG 5
`define CTC_PIN_NUM 6

// Counter limits.
`define CTC_BYTE_ONE 8'h01
`define CTC_BYTE_MAX 8'hff
`define CTC_WORD_ONE 16'h0001
`define CTC_WORD_MAX 16'hffff
`define CTC_LOW5_MASK 8'h1f

`endif

// File: rtl/ctc_pkg.sv
package ctc_pkg;

	// Operating mode of a first or second timer.
	typedef enum logic [1:0] {
		CTC_MODE13 = 2'h0,
		CTC_MODE16 = 2'h1,
		CTC_MODE8R = 2'h2,
		CTC_SPLIT = 2'h3
	} ctc_mode_t;

	// One nibble of the mode register.
	typedef struct packed {
		logic gate;
		logic ext_src;
		ctc_mode_t mode;
	} ctc_tmode_t;

	// Next byte pair and wrap of one counting step.
	typedef struct packed {
		logic [7:0] lo;
		logic [7:0] hi;
		logic wrap;
	} ctc_step_t;

endpackage : ctc_pkg

// File: rtl/ctc_timers.sv
`timescale 1ns/10ps
`include "ctc_params.svh"

// How it works
// - Mode 0 counts high byte plus five bits
// - Wrap to zero sets the overflow flag
// - Count needs run (second timer: or first split) and gate off or pin high
// - Setting run leaves count registers untouched
// - Timer function counts every core clock
// - Mode 1 uses full sixteen bits
// - Mode 2 reloads low byte from high
// - Second timer in mode 3 holds count
// - Split low byte uses first timer controls
// - Split high byte uses second run, flag
// - Second timer still ticks baud when split
// - Third overflow flag blocked while baud selected
// - Trigger edge capture or reload sets flag
// - Select bits route third timer overflows to serial
// - Trigger enable ignored while clocking serial port
// - Third timer run bit starts and stops
// - Third source bit picks pin or clock
// - Capture select picks capture or reload
// - Baud selection forces reload on overflow
// - Data bytes and control reset to zero
// - Mode field encodes the four modes
// - Vector acknowledge clears first, second flags
// - Source bit picks pin or system clock
module ctc_timers (
	// Clock and reset.
	input wire logic CORE_CLK,
	input wire logic RST,
	// Register port.
	input wire logic [7:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR_STB,
	input wire logic RD_STB,
	output logic [7:0] RDATA,
	// Interrupt vector acknowledges from the core.
	input wire logic FIRST_TIMER_VECTOR_ACK,
	input wire logic SECOND_TIMER_VECTOR_ACK,
	// External pins.
	input wire logic FIRST_TIMER_COUNT_PIN,
	input wire logic SECOND_TIMER_COUNT_PIN,
	input wire logic EXTERNAL_GATE_INTERRUPT_PIN,
	input wire logic EXTERNAL_GATE_INTERRUPT_PIN1,
	input wire logic THIRD_TIMER_COUNT_PIN,
	input wire logic TRIGGER_INPUT_PIN,
	// Flags and serial clock ticks.
	output logic FIRST_TIMER_OVERFLOW_FLAG,
	output logic SECOND_TIMER_OVERFLOW_FLAG,
	output logic THIRD_TIMER_OVERFLOW_FLAG,
	output logic THIRD_TIMER_EXTERNAL_FLAG,
	output logic RX_BAUD_TICK,
	output logic TX_BAUD_TICK
);

	// One counting step of a first or second timer in modes 0 to 2.
	function automatic ctc_pkg::ctc_step_t ctc_step(input ctc_pkg::ctc_mode_t mode,
			input logic [7:0] lo, input logic [7:0] hi);
		ctc_pkg::ctc_step_t r;
		logic [13:0] w13;
		logic [16:0] w16;
		r.lo = lo;
		r.hi = hi;
		r.wrap = 1'b0;
		w13 = {1'b0, hi, lo[4:0]} + {6'h00, `CTC_BYTE_ONE};
		w16 = {1'b0, hi, lo} + {1'b0, `CTC_WORD_ONE};
		case (mode)
			ctc_pkg::CTC_MODE13: begin
				// Upper three low-byte bits are left alone.
				{r.wrap, r.hi, r.lo[4:0]} = w13;
			end
			ctc_pkg::CTC_MODE16: begin
				{r.wrap, r.hi, r.lo} = w16;
			end
			ctc_pkg::CTC_MODE8R: begin
				if (lo == `CTC_BYTE_MAX) begin
					r.lo = hi;
					r.wrap = 1'b1;
				end else begin
					r.lo = lo + `CTC_BYTE_ONE;
				end
			end
			default: begin
				r.wrap = 1'b0;
			end
		endcase
		return r;
	endfunction : ctc_step

	logic [`CTC_PIN_NUM-1:0] pins;
	logic [`CTC_PIN_NUM-1:0] sync1_q;
	logic [`CTC_PIN_NUM-1:0] sync2_q;
	logic [`CTC_PIN_NUM-1:0] sync3_q;
	logic [`CTC_PIN_NUM-1:0] fall;

	logic [7:0] lo0_q, hi0_q, lo1_q, hi1_q;
	logic [7:0] lo0_d, hi0_d, lo1_d, hi1_d;
	ctc_pkg::ctc_tmode_t tm0_q, tm1_q;
	logic run0_q, run1_q, ovf0_q, ovf1_q;
	logic inc0, inc1, set0, set1, wrap1, split0;
	ctc_pkg::ctc_step_t st0, st1;

	logic ovf2_q, ext2_q, rxsel_q, txsel_q, trig_en_q, run2_q, src2_q, capsel_q;
	logic [15:0] tmr2_q, rld_q, tmr2_d, rld_d;
	logic baud, inc2, wrap2, trig, reload2, capture2;
	logic [7:0] rd_d;
	logic wr_ctl, wr_mode, wr_lo0, wr_hi0, wr_lo1, wr_hi1, wr_c2;
	logic wr_rl, wr_rh, wr_cl, wr_ch;

	// Pins pass two flip-flops; the third stage feeds edge detection.
	assign pins = {TRIGGER_INPUT_PIN, THIRD_TIMER_COUNT_PIN, EXTERNAL_GATE_INTERRUPT_PIN1,
		EXTERNAL_GATE_INTERRUPT_PIN, SECOND_TIMER_COUNT_PIN, FIRST_TIMER_COUNT_PIN};

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			sync1_q <= '0;
			sync2_q <= '0;
			sync3_q <= '0;
		end else begin
			sync1_q <= pins;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
		end
	end

	assign fall = sync3_q & ~sync2_q;

	// Write decode.
	assign wr_ctl = WR_STB && (ADDR == `CTC_OFS_CONTROL);
	assign wr_mode = WR_STB && (ADDR == `CTC_OFS_MODE);
	assign wr_lo0 = WR_STB && (ADDR == `CTC_OFS_LO0);
	assign wr_hi0 = WR_STB && (ADDR == `CTC_OFS_HI0);
	assign wr_lo1 = WR_STB && (ADDR == `CTC_OFS_LO1);
	assign wr_hi1 = WR_STB && (ADDR == `CTC_OFS_HI1);
	assign wr_c2 = WR_STB && (ADDR == `CTC_OFS_CTL2);
	assign wr_rl = WR_STB && (ADDR == `CTC_OFS_RLD2_LO);
	assign wr_rh = WR_STB && (ADDR == `CTC_OFS_RLD2_HI);
	assign wr_cl = WR_STB && (ADDR == `CTC_OFS_THIRD_TIMER_COUNT_SOURCE_LO);
	assign wr_ch = WR_STB && (ADDR == `CTC_OFS_THIRD_TIMER_COUNT_SOURCE_HI);

	// Count enables for the first and second timers.
	assign split0 = (tm0_q.mode == ctc_pkg::CTC_SPLIT);
	assign inc0 = run0_q && (!tm0_q.gate || sync2_q[`CTC_PIN_GATE0])
		&& (tm0_q.ext_src ? fall[`CTC_PIN_CNT0] : 1'b1);
	// While the first timer is split, the second is switched only by its own mode 3.
	assign inc1 = (tm1_q.mode != ctc_pkg::CTC_SPLIT)
		&& (split0 || run1_q)
		&& (!tm1_q.gate || sync2_q[`CTC_PIN_GATE1])
		&& (tm1_q.ext_src ? fall[`CTC_PIN_CNT1] : 1'b1);

	always_comb begin
		st0 = ctc_step(tm0_q.mode, lo0_q, hi0_q);
		st1 = ctc_step(tm1_q.mode, lo1_q, hi1_q);
		lo0_d = lo0_q;
		hi0_d = hi0_q;
		lo1_d = lo1_q;
		hi1_d = hi1_q;
		set0 = 1'b0;
		set1 = 1'b0;
		wrap1 = 1'b0;
		if (split0) begin
			if (inc0) begin
				lo0_d = lo0_q + `CTC_BYTE_ONE;
				set0 = (lo0_q == `CTC_BYTE_MAX);
			end
			if (run1_q) begin
				hi0_d = hi0_q + `CTC_BYTE_ONE;
				set1 = (hi0_q == `CTC_BYTE_MAX);
			end
		end else if (inc0) begin
			lo0_d = st0.lo;
			hi0_d = st0.hi;
			set0 = st0.wrap;
		end
		if (inc1) begin
			lo1_d = st1.lo;
			hi1_d = st1.hi;
			wrap1 = st1.wrap;
			if (!split0) begin
				set1 = st1.wrap;
			end
		end
	end

	// Count registers; a software write wins over counting.
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			lo0_q <= `CTC_RST_BYTE;
			hi0_q <= `CTC_RST_BYTE;
			lo1_q <= `CTC_RST_BYTE;
			hi1_q <= `CTC_RST_BYTE;
		end else begin
			lo0_q <= wr_lo0 ? WDATA : lo0_d;
			hi0_q <= wr_hi0 ? WDATA : hi0_d;
			lo1_q <= wr_lo1 ? WDATA : lo1_d;
			hi1_q <= wr_hi1 ? WDATA : hi1_d;
		end
	end

	// Mode register and run bits; run never touches the count.
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			tm0_q <= ctc_pkg::ctc_tmode_t'(4'h0);
			tm1_q <= ctc_pkg::ctc_tmode_t'(4'h0);
			run0_q <= 1'b0;
			run1_q <= 1'b0;
		end else begin
			if (wr_mode) begin
				tm0_q <= ctc_pkg::ctc_tmode_t'(WDATA[`CTC_MODE_T0_LSB +: 4]);
				tm1_q <= ctc_pkg::ctc_tmode_t'(WDATA[`CTC_MODE_T1_LSB +: 4]);
			end
			if (wr_ctl) begin
				run0_q <= WDATA[`CTC_CTL_RUN0];
				run1_q <= WDATA[`CTC_CTL_RUN1];
			end
		end
	end

	// Overflow flags: hardware set wins over acknowledge and software write.
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			ovf0_q <= 1'b0;
			ovf1_q <= 1'b0;
		end else begin
			if (set0) begin
				ovf0_q <= 1'b1;
			end else if (wr_ctl) begin
				ovf0_q <= WDATA[`CTC_CTL_OVF0];
			end else if (FIRST_TIMER_VECTOR_ACK) begin
				ovf0_q <= 1'b0;
			end
			if (set1) begin
				ovf1_q <= 1'b1;
			end else if (wr_ctl) begin
				ovf1_q <= WDATA[`CTC_CTL_OVF1];
			end else if (SECOND_TIMER_VECTOR_ACK) begin
				ovf1_q <= 1'b0;
			end
		end
	end

	// Third timer datapath.
	assign baud = rxsel_q || txsel_q;
	assign inc2 = run2_q && (src2_q ? fall[`CTC_PIN_THIRD_TIMER_COUNT_SOURCE] : 1'b1);
	assign wrap2 = inc2 && (tmr2_q == `CTC_WORD_MAX);
	assign trig = trig_en_q && fall[`CTC_PIN_TRIG] && !baud;
	assign capture2 = trig && capsel_q;
	assign reload2 = (trig && !capsel_q) || (wrap2 && (baud || !capsel_q));

	always_comb begin
		tmr2_d = tmr2_q;
		rld_d = rld_q;
		if (reload2) begin
			tmr2_d = rld_q;
		end else if (inc2) begin
			tmr2_d = tmr2_q + `CTC_WORD_ONE;
		end
		if (capture2) begin
			rld_d = tmr2_q;
		end
		if (wr_cl) begin
			tmr2_d[7:0] = WDATA;
		end
		if (wr_ch) begin
			tmr2_d[15:8] = WDATA;
		end
		if (wr_rl) begin
			rld_d[7:0] = WDATA;
		end
		if (wr_rh) begin
			rld_d[15:8] = WDATA;
		end
	end

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			tmr2_q <= `CTC_RST_WORD;
			rld_q <= `CTC_RST_WORD;
		end else begin
			tmr2_q <= tmr2_d;
			rld_q <= rld_d;
		end
	end

	// Third timer control register.
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			ovf2_q <= 1'b0;
			ext2_q <= 1'b0;
			rxsel_q <= 1'b0;
			txsel_q <= 1'b0;
			trig_en_q <= 1'b0;
			run2_q <= 1'b0;
			src2_q <= 1'b0;
			capsel_q <= 1'b0;
		end else begin
			if (wr_c2) begin
				rxsel_q <= WDATA[`CTC_C2_RXSEL];
				txsel_q <= WDATA[`CTC_C2_TXSEL];
				trig_en_q <= WDATA[`CTC_C2_TRIGEN];
				run2_q <= WDATA[`CTC_C2_RUN];
				src2_q <= WDATA[`CTC_C2_SRC];
				capsel_q <= WDATA[`CTC_C2_CAPSEL];
			end
			if (wrap2 && !baud) begin
				ovf2_q <= 1'b1;
			end else if (wr_c2) begin
				ovf2_q <= WDATA[`CTC_C2_OVF];
			end
			if (trig) begin
				ext2_q <= 1'b1;
			end else if (wr_c2) begin
				ext2_q <= WDATA[`CTC_C2_EXT];
			end
		end
	end

	// Serial clock ticks: third timer overflows where selected, else the second.
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			RX_BAUD_TICK <= 1'b0;
			TX_BAUD_TICK <= 1'b0;
		end else begin
			RX_BAUD_TICK <= rxsel_q ? wrap2 : wrap1;
			TX_BAUD_TICK <= txsel_q ? wrap2 : wrap1;
		end
	end

	// Read mux; unmapped addresses read zero.
	always_comb begin
		case (ADDR)
			`CTC_OFS_CONTROL: rd_d = {ovf1_q, run1_q, ovf0_q, run0_q, 4'h0};
			`CTC_OFS_MODE: rd_d = {tm1_q, tm0_q};
			`CTC_OFS_LO0: rd_d = lo0_q;
			`CTC_OFS_HI0: rd_d = hi0_q;
			`CTC_OFS_LO1: rd_d = lo1_q;
			`CTC_OFS_HI1: rd_d = hi1_q;
			`CTC_OFS_CTL2: rd_d = {ovf2_q, ext2_q, rxsel_q, txsel_q, trig_en_q, run2_q,
				src2_q, capsel_q};
			`CTC_OFS_RLD2_LO: rd_d = rld_q[7:0];
			`CTC_OFS_RLD2_HI: rd_d = rld_q[15:8];
			`CTC_OFS_THIRD_TIMER_COUNT_SOURCE_LO: rd_d = tmr2_q[7:0];
			`CTC_OFS_THIRD_TIMER_COUNT_SOURCE_HI: rd_d = tmr2_q[15:8];
			default: rd_d = `CTC_RST_BYTE;
		endcase
	end

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			RDATA <= `CTC_RST_BYTE;
			FIRST_TIMER_OVERFLOW_FLAG <= 1'b0;
			SECOND_TIMER_OVERFLOW_FLAG <= 1'b0;
			THIRD_TIMER_OVERFLOW_FLAG <= 1'b0;
			THIRD_TIMER_EXTERNAL_FLAG <= 1'b0;
		end else begin
			RDATA <= RD_STB ? rd_d : `CTC_RST_BYTE;
			FIRST_TIMER_OVERFLOW_FLAG <= ovf0_q;
			SECOND_TIMER_OVERFLOW_FLAG <= ovf1_q;
			THIRD_TIMER_OVERFLOW_FLAG <= ovf2_q;
			THIRD_TIMER_EXTERNAL_FLAG <= ext2_q;
		end
	end

	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (RST);

	logic quiet0, quiet1;
	assign quiet0 = !wr_lo0 && !wr_hi0;
	assign quiet1 = !wr_lo1 && !wr_hi1;

	sequence s_wrap16;
		inc0 && !split0 && tm0_q.mode == ctc_pkg::CTC_MODE16 && quiet0
			&& {hi0_q, lo0_q} == `CTC_WORD_MAX;
	endsequence

	sequence s_capture;
		capture2 && !wr_rl && !wr_rh;
	endsequence

	mode13_upper_a: assert property (tm0_q.mode == ctc_pkg::CTC_MODE13 && !wr_lo0
		|=> $stable(lo0_q[7:5])) else $error("upper low-byte bits changed in mode 0");
	wrap_flag_a: assert property (s_wrap16 ##1 (lo0_q == `CTC_BYTE_MAX + `CTC_BYTE_ONE)
		|-> ovf0_q && hi0_q == `CTC_RST_BYTE) else $error("wrap did not set flag");
	gate_hold_a: assert property (!split0 && tm0_q.gate && !sync2_q[`CTC_PIN_GATE0]
		&& quiet0 |=> $stable({hi0_q, lo0_q})) else $error("gated timer counted");
	run_keep_a: assert property (wr_ctl && WDATA[`CTC_CTL_RUN0] && !run0_q && quiet0
		&& !(split0 && run1_q)
		|=> $stable({hi0_q, lo0_q})) else $error("run bit changed count");
	clock_rate_a: assert property (run0_q && !tm0_q.gate && !tm0_q.ext_src && quiet0
		&& tm0_q.mode == ctc_pkg::CTC_MODE16 && {hi0_q, lo0_q} != `CTC_WORD_MAX
		|=> {hi0_q, lo0_q} == $past({hi0_q, lo0_q}) + `CTC_WORD_ONE)
		else $error("timer did not step every clock");
	reload8_a: assert property (inc0 && tm0_q.mode == ctc_pkg::CTC_MODE8R && quiet0
		&& lo0_q == `CTC_BYTE_MAX |=> lo0_q == $past(hi0_q) && $stable(hi0_q) && ovf0_q)
		else $error("mode 2 reload wrong");
	hold1_a: assert property (tm1_q.mode == ctc_pkg::CTC_SPLIT && quiet1
		|=> $stable({hi1_q, lo1_q})) else $error("second timer counted in mode 3");
	split_high_a: assert property (split0 && run1_q && !wr_hi0
		&& hi0_q == `CTC_BYTE_MAX |=> ovf1_q && hi0_q == `CTC_RST_BYTE)
		else $error("split high byte overflow lost");
	ovf2_block_a: assert property (baud && !wr_c2 |=> !$rose(ovf2_q))
		else $error("third overflow flag set in baud mode");
	ext_flag_a: assert property (trig |=> ext2_q)
		else $error("trigger edge did not set external flag");
	rx_route_a: assert property (rxsel_q && wrap2 |=> RX_BAUD_TICK)
		else $error("receive tick not routed");
	trig_ignore_a: assert property (baud && fall[`CTC_PIN_TRIG] && !wr_rl && !wr_rh
		&& !wr_c2
		|=> $stable(rld_q) && !$rose(ext2_q)) else $error("trigger acted in baud mode");
	stop2_a: assert property (!run2_q && !trig && !wr_cl && !wr_ch
		|=> $stable(tmr2_q)) else $error("stopped third timer moved");
	capture_a: assert property (s_capture |=> rld_q == $past(tmr2_q))
		else $error("capture value wrong");
	force_reload_a: assert property (wrap2 && baud && !wr_cl && !wr_ch
		|=> tmr2_q == $past(rld_q)) else $error("baud mode did not reload");
	ack_clear_a: assert property (FIRST_TIMER_VECTOR_ACK && !set0 && !wr_ctl
		|=> !ovf0_q ##1 !FIRST_TIMER_OVERFLOW_FLAG) else $error("acknowledge did not clear");

endmodule : ctc_timers

// File: test/ctc_pin_model.sv
`timescale 1ns/10ps
module ctc_pin_model (
	// Clock.
	input wire logic clk,
	// One-cycle requests, one bit for each pin.
	input wire logic [3:0] fire,
	// Pins towards the timers, idle high.
	output logic [3:0] pins
);
	logic [1:0] hold_q [4];

	initial begin
		pins = 4'hf;
		for (int i = 0; i < 4; i++) hold_q[i] = 2'h0;
	end

	// Each request gives one low phase of three clocks, so both levels outlast the synchroniser.
	always @(posedge clk) begin
		for (int i = 0; i < 4; i++) begin
			if (fire[i]) begin
				pins[i] <= 1'h0;
				hold_q[i] <= 2'h3;
			end else if (hold_q[i] != 2'h0) begin
				hold_q[i] <= hold_q[i] - 2'h1;
				pins[i] <= (hold_q[i] == 2'h1);
			end
		end
	end
endmodule : ctc_pin_model

// File: test/tb.sv
`timescale 1ns/10ps
`include "ctc_params.svh"
module tb;
	localparam logic [7:0] CT = `CTC_OFS_CONTROL, MD = `CTC_OFS_MODE, L0 = `CTC_OFS_LO0,
		L1 = `CTC_OFS_LO1, H0 = `CTC_OFS_HI0, H1 = `CTC_OFS_HI1, C2 = `CTC_OFS_CTL2,
		R2L = `CTC_OFS_RLD2_LO, R2H = `CTC_OFS_RLD2_HI, N2L = `CTC_OFS_THIRD_TIMER_COUNT_SOURCE_LO,
		N2H = `CTC_OFS_THIRD_TIMER_COUNT_SOURCE_HI;
	logic clk = 1'h0, rst = 1'h1, bus_w = 1'h0, bus_r = 1'h0, rpend = 1'h0;
	logic ack0 = 1'h0, ack1 = 1'h0, g0 = 1'h0, g1 = 1'h0;
	logic [7:0] bus_a = 8'h00, bus_d = 8'h00, nrx = 8'h00, ntx = 8'h00, rdata, r0, t0;
	logic [3:0] fire = 4'h0, pins;
	logic f0, f1, f2, e2, rxt, txt;
	logic [15:0] q [$];
	logic [15:0] rs = 16'ha966, v, e;
	int errors = 0, n_compared = 0;
	int n;

	always #2.5 clk = ~clk;

	ctc_pin_model pin_u (.clk(clk), .fire(fire), .pins(pins));
	ctc_timers dut_u (.CORE_CLK(clk), .RST(rst), .ADDR(bus_a), .WDATA(bus_d), .WR_STB(bus_w),
		.RD_STB(bus_r), .RDATA(rdata), .FIRST_TIMER_VECTOR_ACK(ack0),
		.SECOND_TIMER_VECTOR_ACK(ack1), .FIRST_TIMER_COUNT_PIN(pins[0]),
		.SECOND_TIMER_COUNT_PIN(pins[1]), .EXTERNAL_GATE_INTERRUPT_PIN(g0),
		.EXTERNAL_GATE_INTERRUPT_PIN1(g1), .THIRD_TIMER_COUNT_PIN(pins[2]),
		.TRIGGER_INPUT_PIN(pins[3]), .FIRST_TIMER_OVERFLOW_FLAG(f0),
		.SECOND_TIMER_OVERFLOW_FLAG(f1), .THIRD_TIMER_OVERFLOW_FLAG(f2),
		.THIRD_TIMER_EXTERNAL_FLAG(e2), .RX_BAUD_TICK(rxt), .TX_BAUD_TICK(txt));

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr

	task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] sn);
		n_compared++;
		if (sn !== ex) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", nm, ex, sn);
		end
	endtask : chk

	task automatic give_verdict();
		if (errors == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : give_verdict

	task automatic cyc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
		bus_w <= w;
		bus_r <= r;
		bus_a <= a;
		bus_d <= d;
		@(posedge clk);
	endtask : cyc

	task automatic idles(input int k);
		repeat (k) cyc(1'h0, 1'h0, 8'h00, 8'h00);
	endtask : idles

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		cyc(1'h1, 1'h0, a, d);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] ex);
		q.push_back({a, ex});
		cyc(1'h0, 1'h1, a, 8'h00);
	endtask : rd

	// Start at one write and stop at the k-th edge after it, so exactly k clocks are counted.
	task automatic runt(input logic [7:0] a, input logic [7:0] c, input int k);
		wr(a, c);
		idles(k - 1);
		wr(a, 8'h00);
	endtask : runt

	task automatic pulse(input int i, input int k);
		repeat (k) begin
			fire[i] <= 1'h1;
			idles(1);
			fire[i] <= 1'h0;
			idles(6);
		end
	endtask : pulse

	// Read data stand only in the cycle after the strobe, so they are sampled at that edge.
	always @(posedge clk) begin
		if (rpend) begin : pop_b
			logic [15:0] x;
			x = q.pop_front();
			chk($sformatf("reg %h", x[15:8]), x[7:0], rdata);
		end
		rpend <= bus_r;
		if (rxt === 1'h1)
			nrx <= nrx + 8'h01;
		if (txt === 1'h1)
			ntx <= ntx + 8'h01;
	end

	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		give_verdict();
	end

	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'h0;
		rd(L0, 8'h00);
		rd(L1, 8'h00);
		rd(H0, 8'h00);
		rd(H1, 8'h00);
		rd(C2, 8'h00);
		rd(8'h00, 8'h00);
		rs = lfsr(rs);
		v = {1'h0, rs[14:0]};
		rs = lfsr(rs);
		n = 3 + rs[2:0];
		wr(MD, 8'h01);
		wr(L0, v[7:0]);
		wr(H0, v[15:8]);
		runt(CT, 8'h10, n);
		e = v + 16'(n);
		rd(L0, e[7:0]);
		rd(H0, e[15:8]);
		wr(MD, 8'h00);
		wr(L0, 8'h1e);
		wr(H0, 8'h00);
		runt(CT, 8'h10, 2);
		rd(L0, 8'h00);
		rd(H0, 8'h01);
		wr(L0, 8'h1f);
		wr(H0, 8'hff);
		runt(CT, 8'h10, 1);
		rd(H0, 8'h00);
		rd(CT, 8'h20);
		idles(2);
		chk("flag0", 8'h01, {7'h00, f0});
		ack0 <= 1'h1;
		idles(1);
		ack0 <= 1'h0;
		idles(3);
		chk("flag0", 8'h00, {7'h00, f0});
		rd(CT, 8'h00);
		wr(MD, 8'h02);
		wr(L0, 8'hff);
		wr(H0, 8'ha5);
		runt(CT, 8'h10, 1);
		rd(L0, 8'ha5);
		rd(H0, 8'ha5);
		rd(CT, 8'h20);
		wr(MD, 8'h09);
		wr(L0, 8'h00);
		wr(H0, 8'h00);
		runt(CT, 8'h10, 10);
		rd(L0, 8'h00);
		g0 <= 1'h1;
		idles(4);
		runt(CT, 8'h10, 10);
		rd(L0, 8'h0a);
		g0 <= 1'h0;
		wr(MD, 8'h55);
		wr(L0, 8'h00);
		wr(L1, 8'h00);
		wr(CT, 8'h50);
		pulse(0, 3);
		pulse(1, 2);
		wr(CT, 8'h00);
		rd(L0, 8'h03);
		rd(L1, 8'h02);
		wr(MD, 8'h33);
		wr(L0, 8'h00);
		wr(H0, 8'h00);
		wr(L1, 8'h40);
		runt(CT, 8'h50, 5);
		rd(L0, 8'h05);
		rd(H0, 8'h05);
		rd(L1, 8'h40);
		wr(H0, 8'hff);
		runt(CT, 8'h40, 1);
		rd(CT, 8'h80);
		idles(2);
		chk("flag1", 8'h01, {7'h00, f1});
		ack1 <= 1'h1;
		idles(1);
		ack1 <= 1'h0;
		wr(L0, 8'hff);
		runt(CT, 8'h10, 1);
		rd(CT, 8'h20);
		wr(CT, 8'h00);
		idles(3);
		r0 = nrx;
		t0 = ntx;
		// Timer 1 leaves its mode 3 for one clock and wraps once.
		wr(L1, 8'hff);
		wr(H1, 8'hff);
		wr(MD, 8'h13);
		wr(MD, 8'h33);
		rd(H1, 8'h00);
		rd(CT, 8'h00);
		wr(N2L, 8'hfe);
		wr(N2H, 8'hff);
		runt(C2, 8'h04, 2);
		rd(N2L, 8'h00);
		rd(N2H, 8'h00);
		rd(C2, 8'h80);
		idles(2);
		chk("flag2", 8'h01, {7'h00, f2});
		// With receive select the wrap reloads although capture is chosen.
		wr(R2L, 8'hf0);
		wr(R2H, 8'hff);
		wr(N2L, 8'hff);
		wr(N2H, 8'hff);
		runt(C2, 8'h25, 1);
		rd(C2, 8'h00);
		rd(N2L, 8'hf0);
		rd(N2H, 8'hff);
		idles(3);
		chk("rx ticks", r0 + 8'h02, nrx);
		chk("tx ticks", t0 + 8'h01, ntx);
		wr(N2L, 8'h34);
		wr(N2H, 8'h12);
		wr(C2, 8'h0f);
		pulse(3, 1);
		rd(R2L, 8'h34);
		rd(R2H, 8'h12);
		rd(N2L, 8'h34);
		rd(C2, 8'h4f);
		chk("xflag2", 8'h01, {7'h00, e2});
		wr(C2, 8'h06);
		wr(N2L, 8'h78);
		pulse(3, 1);
		rd(R2L, 8'h34);
		rd(C2, 8'h06);
		pulse(2, 2);
		rd(N2L, 8'h7a);
		wr(C2, 8'h0e);
		pulse(3, 1);
		rd(N2L, 8'h34);
		rd(C2, 8'h4e);
		// Trigger enabled but the receive select is set, so the edge must be ignored.
		wr(C2, 8'h2b);
		pulse(3, 1);
		rd(R2L, 8'h34);
		rd(C2, 8'h2b);
		wr(C2, 8'h00);
		idles(3);
		give_verdict();
	end
endmodule : tb
